/* File: verilog/bdr_receiver.sv */
// Purpose: Data-link channel message receiver and transmitter with registers
// Assumes: rx_dl_valid and tx_dl_req pulse at most every other clk_sys cycle
// Notes:   Avalon-MM slave answers two edges after a request is seen
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps

// Functional notes
// - HDLC receiver and message receiver each have their own enable bit.
// - With both enabled, mode switches automatically from the received bits.
// - Path select 10 routes data-link bits through the receive/transmit queues.
// - Reset or receiver-reset command starts the receiver in HDLC mode.
// - In HDLC mode, eight consecutive ones enter message mode.
// - In message mode, an HDLC flag returns to HDLC mode.
// - Message mode accepts an HDLC frame at once, no leading flags.
// - Expected word: eight ones, then a byte starting and ending with zero.
// - Sync on FF; store next byte LSB first only if zero-bounded.
// - Bytes with first and last bit one are discarded.
// - No 8-ones run in 32 bits raises an event; sampling continues.
// - Packet mode: status byte after every 10 bytes plus message-end event.
// - Continuous mode: event every 32/16/4/2 bytes; flag ends with status.
// - Filter mode: accept pattern seen 7 of 10, store it with status.
// - Filter mode shows valid state; losing the pattern raises an event.
// - Reception mode may change at any time without reset.
// - Disabling message receiver appends status, raises event, enters HDLC.
// - A status bit shows HDLC or message mode.
// - Data-link bits latched per receive multiframe into three registers.
// - Register transmit sends three registers per multiframe and raises event.
// - With path enable cleared, link bits neither enter nor leave the queues.
module bdr_receiver (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic [bdr_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        rx_dl_bit,
  input  wire logic                        rx_dl_valid,
  input  wire logic                        rx_mf_begin,
  input  wire logic                        tx_dl_req,
  input  wire logic                        tx_mf_begin,
  output logic                             tx_dl_bit
);
  bdr_mem_if rxm ();
  bdr_mem_if txm ();

  logic [bdr_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [bdr_pkg::EVT_W-1:0]  evt_q, evt_d, evt_set;
  logic                       busy_q, busy_d, wait_q, wait_d;
  logic [31:0]                rdata_q, rdata_d;
  bdr_pkg::bdr_mode_type      mode_q, mode_d;
  logic [7:0]                 hist_q, hist_d, byte_q, byte_d;
  logic [3:0]                 ones_q, ones_d, bcnt_q, bcnt_d, pkt_q, pkt_d;
  logic [5:0]                 nosync_q, nosync_d, pool_q, pool_d, pool_lim;
  logic                       pend_q, pend_d;
  logic [4:0]                 rwp_q, rwp_d, rrp_q, rrp_d, twp_q, twp_d, trp_q, trp_d;
  logic [5:0]                 rcnt_q, rcnt_d, tcnt_q, tcnt_d;
  logic [bdr_pkg::DL_BITS-1:0] rsh_q, rsh_d, rdl_q, rdl_d, xdl_q, xdl_d, xsh_q, xsh_d;
  logic [7:0]                 tsh_q, tsh_d;
  logic [3:0]                 tleft_q, tleft_d;
  logic                       tbit_q, tbit_d;
  logic                       tpushed_q;
  logic                       push, pop, tpush, tpop, rx_rst, acc, do_wr, do_rd;
  logic [7:0]                 push_data;
  logic                       path_on, filt_load, filt_accept, filt_lost, filt_valid;
  logic [7:0]                 filt_pat, filt_in;

  // Data-link bits use the queues only with path select 10
  assign path_on = ctrl_q[bdr_pkg::C_DL_PATH] && !ctrl_q[bdr_pkg::C_SLOT_PATH];
  assign acc     = (avs_read || avs_write) && wait_q && !busy_q;
  assign do_wr   = busy_q && avs_write;
  assign do_rd   = busy_q && avs_read;
  assign rx_rst  = do_wr && avs_address == bdr_pkg::ADR_CMD && avs_writedata[bdr_pkg::CMD_RX_RESET];

  always_comb begin
    case (ctrl_q[bdr_pkg::C_POOL_LO +: 2])
      2'b00:   pool_lim = bdr_pkg::POOL_32;
      2'b01:   pool_lim = bdr_pkg::POOL_16;
      2'b10:   pool_lim = bdr_pkg::POOL_4;
      default: pool_lim = bdr_pkg::POOL_2;
    endcase
  end

  // Receive state machine and receive queue
  always_comb begin
    mode_d    = mode_q;
    hist_d    = hist_q;
    byte_d    = byte_q;
    ones_d    = ones_q;
    bcnt_d    = bcnt_q;
    pkt_d     = pkt_q;
    pool_d    = pool_q;
    nosync_d  = nosync_q;
    pend_d    = pend_q;
    push      = 1'b0;
    push_data = 8'h00;
    filt_load = 1'b0;
    filt_in   = 8'h00;
    evt_set   = '0;
    if (rx_dl_valid && path_on) begin
      hist_d = {hist_q[6:0], rx_dl_bit};
      byte_d = {rx_dl_bit, byte_q[7:1]};
      ones_d = !rx_dl_bit ? 4'h0 : (ones_q == bdr_pkg::ONES_RUN) ? ones_q : ones_q + 4'h1;
      case (mode_q)
        bdr_pkg::BDR_ST_HDLC: begin
          if (ctrl_q[bdr_pkg::C_MSG_ACT] && ones_d == bdr_pkg::ONES_RUN) begin
            mode_d   = bdr_pkg::BDR_ST_MSG;
            bcnt_d   = bdr_pkg::BYTE_FIRST;
            nosync_d = 6'h00;
            pkt_d    = 4'h0;
            pool_d   = 6'h00;
          end else if (ctrl_q[bdr_pkg::C_HDLC_ACT]) begin
            // Raw octets; framing is left to the HDLC engine downstream
            bcnt_d = {1'b0, bcnt_q[2:0] + 3'h1};
            if (bcnt_q[2:0] == 3'h7) begin
              push      = 1'b1;
              push_data = byte_d;
            end
          end
        end
        bdr_pkg::BDR_ST_MSG: begin
          if (hist_d == bdr_pkg::FLAG_BYTE) begin
            mode_d = bdr_pkg::BDR_ST_HDLC;
            bcnt_d = 4'h0;
            if (ctrl_q[bdr_pkg::C_RX_MODE] && !ctrl_q[bdr_pkg::C_FILTER]) begin
              pend_d = 1'b1;
              evt_set[bdr_pkg::E_MSG_END] = 1'b1;
            end
          end else begin
            if (ones_d == bdr_pkg::ONES_RUN) begin
              nosync_d = 6'h00;
            end else if (nosync_q == bdr_pkg::SYNC_WINDOW - 6'h01) begin
              nosync_d = 6'h00;
              evt_set[bdr_pkg::E_NO_SYNC] = 1'b1;
            end else begin
              nosync_d = nosync_q + 6'h01;
            end
            // Longer runs of ones keep moving the sync point, so a byte ending in one cannot skew it
            if (hist_d == bdr_pkg::SYNC_BYTE && bcnt_q <= bdr_pkg::BYTE_FIRST) begin
              bcnt_d = bdr_pkg::BYTE_FIRST;
            end else if (bcnt_q == bdr_pkg::BYTE_LAST) begin
              // Sampling keeps its old alignment when sync is missing
              bcnt_d = 4'h0;
              if (!byte_d[0] && !byte_d[7]) begin
                if (ctrl_q[bdr_pkg::C_FILTER]) begin
                  filt_load = 1'b1;
                  filt_in   = byte_d;
                end else begin
                  push      = 1'b1;
                  push_data = byte_d;
                  if (!ctrl_q[bdr_pkg::C_RX_MODE]) begin
                    pkt_d = pkt_q + 4'h1;
                    if (pkt_q + 4'h1 == bdr_pkg::PACKET_BYTES) begin
                      pkt_d  = 4'h0;
                      pend_d = 1'b1;
                      evt_set[bdr_pkg::E_MSG_END] = 1'b1;
                    end
                  end else begin
                    pool_d = pool_q + 6'h01;
                    if (pool_q + 6'h01 >= pool_lim) begin
                      pool_d = 6'h00;
                      evt_set[bdr_pkg::E_POOL] = 1'b1;
                    end
                  end
                end
              end // Other bytes, e.g. one-bounded, are dropped
            end else begin
              bcnt_d = bcnt_q + 4'h1;
            end
          end
        end
        default: mode_d = bdr_pkg::BDR_ST_HDLC;
      endcase
    end
    if (mode_q == bdr_pkg::BDR_ST_MSG && !ctrl_q[bdr_pkg::C_MSG_ACT]) begin
      mode_d = bdr_pkg::BDR_ST_HDLC;
      pend_d = 1'b1;
      bcnt_d = 4'h0;
      evt_set[bdr_pkg::E_MSG_END] = 1'b1;
    end
    if (filt_accept) begin
      push      = 1'b1;
      push_data = filt_pat;
      pend_d    = 1'b1;
      evt_set[bdr_pkg::E_MSG_END] = 1'b1;
    end
    if (filt_lost) begin
      evt_set[bdr_pkg::E_PAT_INV] = 1'b1;
    end
    // Status byte waits for a free push slot
    if (pend_q && !push) begin
      push      = 1'b1;
      push_data = bdr_pkg::STATUS_BYTE;
      pend_d    = 1'b0;
    end
    if (push && rcnt_q == bdr_pkg::FIFO_DEPTH) begin
      push = 1'b0;
      evt_set[bdr_pkg::E_RX_OVF] = 1'b1;
    end
    if (rx_rst) begin
      mode_d   = bdr_pkg::BDR_ST_HDLC;
      ones_d   = 4'h0;
      bcnt_d   = 4'h0;
      pkt_d    = 4'h0;
      pool_d   = 6'h00;
      nosync_d = 6'h00;
      pend_d   = 1'b0;
      push     = 1'b0;
    end
  end

  // Queue pop and push, bus side and data-link registers
  always_comb begin
    ctrl_d  = ctrl_q;
    wait_d  = 1'b1;
    busy_d  = acc;
    rdata_d = rdata_q;
    pop     = 1'b0;
    tpush   = 1'b0;
    xdl_d   = xdl_q;
    evt_d   = evt_q;
    if (busy_q) begin
      wait_d = 1'b0;
    end
    if (do_wr) begin
      case (avs_address)
        bdr_pkg::ADR_CTRL: ctrl_d = avs_writedata[bdr_pkg::CTRL_W-1:0];
        bdr_pkg::ADR_EVT:  evt_d  = evt_q & ~avs_writedata[bdr_pkg::EVT_W-1:0];
        bdr_pkg::ADR_TXF:  tpush  = tcnt_q != bdr_pkg::FIFO_DEPTH;
        bdr_pkg::ADR_XDL0: xdl_d[7:0]   = avs_writedata[7:0];
        bdr_pkg::ADR_XDL1: xdl_d[15:8]  = avs_writedata[7:0];
        bdr_pkg::ADR_XDL2: xdl_d[23:16] = avs_writedata[7:0];
        default: ;
      endcase
    end
    if (do_rd) begin
      case (avs_address)
        bdr_pkg::ADR_CTRL: rdata_d = {22'h0, ctrl_q};
        bdr_pkg::ADR_STAT: rdata_d = {18'h0, rcnt_q, 4'h0, tcnt_q == bdr_pkg::FIFO_DEPTH,
                                      rcnt_q == 6'h00, filt_valid,
                                      mode_q == bdr_pkg::BDR_ST_MSG};
        bdr_pkg::ADR_EVT:  rdata_d = {25'h0, evt_q};
        bdr_pkg::ADR_RXF: begin
          pop     = rcnt_q != 6'h00;
          rdata_d = {24'h0, pop ? rxm.rdata : 8'h00};
        end
        bdr_pkg::ADR_RDL0: rdata_d = {24'h0, rdl_q[7:0]};
        bdr_pkg::ADR_RDL1: rdata_d = {24'h0, rdl_q[15:8]};
        bdr_pkg::ADR_RDL2: rdata_d = {24'h0, rdl_q[23:16]};
        bdr_pkg::ADR_XDL0: rdata_d = {24'h0, xdl_q[7:0]};
        bdr_pkg::ADR_XDL1: rdata_d = {24'h0, xdl_q[15:8]};
        bdr_pkg::ADR_XDL2: rdata_d = {24'h0, xdl_q[23:16]};
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
    // Hardware set wins over a same-cycle clear
    evt_d = evt_d | evt_set;
    if (rx_mf_begin) begin
      evt_d[bdr_pkg::E_RX_MF] = 1'b1;
    end
    if (tx_mf_begin && ctrl_q[bdr_pkg::C_DL_REG_TX]) begin
      evt_d[bdr_pkg::E_TX_MF] = 1'b1;
    end
  end

  // Receive and transmit queue bookkeeping and data-link bit registers
  always_comb begin
    rwp_d  = rwp_q + {4'h0, push};
    rrp_d  = rrp_q + {4'h0, pop};
    rcnt_d = rcnt_q + {5'h0, push} - {5'h0, pop};
    twp_d  = twp_q + {4'h0, tpush};
    trp_d  = trp_q + {4'h0, tpop};
    tcnt_d = tcnt_q + {5'h0, tpush} - {5'h0, tpop};
    if (rx_rst) begin
      rwp_d  = 5'h00;
      rrp_d  = 5'h00;
      rcnt_d = 6'h00;
    end
    rsh_d = rx_dl_valid ? {rx_dl_bit, rsh_q[bdr_pkg::DL_BITS-1:1]} : rsh_q;
    rdl_d = rx_mf_begin ? rsh_q : rdl_q;
  end

  // Transmit side: queue path, register path, or idle ones
  always_comb begin
    tsh_d   = tsh_q;
    tleft_d = tleft_q;
    tbit_d  = tbit_q;
    tpop    = 1'b0;
    xsh_d   = xsh_q;
    if (tx_mf_begin && ctrl_q[bdr_pkg::C_DL_REG_TX]) begin
      xsh_d = xdl_q;
    end
    if (tx_dl_req) begin
      if (path_on) begin
        if (tleft_q == 4'h0) begin
          // Registered read port lags a fresh write by one clock
          if (tcnt_q != 6'h00 && !tpushed_q) begin
            tpop    = 1'b1;
            tbit_d  = txm.rdata[0];
            tsh_d   = {1'b1, txm.rdata[7:1]};
            tleft_d = 4'h7;
          end else begin
            tbit_d = 1'b1;
          end
        end else begin
          tbit_d  = tsh_q[0];
          tsh_d   = {1'b1, tsh_q[7:1]};
          tleft_d = tleft_q - 4'h1;
        end
      end else if (ctrl_q[bdr_pkg::C_DL_REG_TX]) begin
        tbit_d = xsh_q[0];
        xsh_d  = {1'b1, xsh_q[bdr_pkg::DL_BITS-1:1]};
      end else begin
        tbit_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q   <= bdr_pkg::CTRL_RESET;
      evt_q    <= '0;
      busy_q   <= 1'b0;
      wait_q   <= 1'b1;
      rdata_q  <= 32'h0000_0000;
      mode_q   <= bdr_pkg::BDR_ST_HDLC;
      hist_q   <= 8'h00;
      byte_q   <= 8'h00;
      ones_q   <= 4'h0;
      bcnt_q   <= 4'h0;
      pkt_q    <= 4'h0;
      pool_q   <= 6'h00;
      nosync_q <= 6'h00;
      pend_q   <= 1'b0;
      rwp_q    <= 5'h00;
      rrp_q    <= 5'h00;
      twp_q    <= 5'h00;
      trp_q    <= 5'h00;
      rcnt_q   <= 6'h00;
      tcnt_q   <= 6'h00;
      rsh_q    <= '0;
      rdl_q    <= '0;
      xdl_q    <= '1;
      xsh_q    <= '1;
      tsh_q    <= 8'hFF;
      tleft_q  <= 4'h0;
      tbit_q   <= 1'b1;
      tpushed_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      evt_q    <= evt_d;
      busy_q   <= busy_d;
      wait_q   <= wait_d;
      rdata_q  <= rdata_d;
      mode_q   <= mode_d;
      hist_q   <= hist_d;
      byte_q   <= byte_d;
      ones_q   <= ones_d;
      bcnt_q   <= bcnt_d;
      pkt_q    <= pkt_d;
      pool_q   <= pool_d;
      nosync_q <= nosync_d;
      pend_q   <= pend_d;
      rwp_q    <= rwp_d;
      rrp_q    <= rrp_d;
      twp_q    <= twp_d;
      trp_q    <= trp_d;
      rcnt_q   <= rcnt_d;
      tcnt_q   <= tcnt_d;
      rsh_q    <= rsh_d;
      rdl_q    <= rdl_d;
      xdl_q    <= xdl_d;
      xsh_q    <= xsh_d;
      tsh_q    <= tsh_d;
      tleft_q  <= tleft_d;
      tbit_q   <= tbit_d;
      tpushed_q <= tpush;
    end
  end

  assign rxm.we    = push;
  assign rxm.waddr = rwp_q;
  assign rxm.wdata = push_data;
  assign rxm.raddr = rrp_q;
  assign txm.we    = tpush;
  assign txm.waddr = twp_q;
  assign txm.wdata = avs_writedata[7:0];
  assign txm.raddr = trp_q;

  bdr_mem u_rx_mem (
    .clk_sys (clk_sys),
    .port    (rxm.mem)
  );

  bdr_mem u_tx_mem (
    .clk_sys (clk_sys),
    .port    (txm.mem)
  );

  // Filter history is dropped when filtering is off so stale patterns never count
  bdr_filter u_filter (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .clear         (rx_rst || !ctrl_q[bdr_pkg::C_FILTER] || mode_q != bdr_pkg::BDR_ST_MSG),
    .load          (filt_load),
    .pattern       (filt_in),
    .accept        (filt_accept),
    .lost          (filt_lost),
    .valid         (filt_valid),
    .valid_pattern (filt_pat)
  );

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign tx_dl_bit       = tbit_q;
endmodule // bdr_receiver

/* File: verilog/bdr_pkg.sv */
// Purpose: Shared constants for the data-link message receiver block
// Assumes: Avalon-MM word registers at byte addresses, 8-bit data-link bytes
// Notes:   Offsets, field positions, the control reset value and counts live here
package bdr_pkg;

  localparam int          ADDR_W        = 6;
  localparam logic [5:0]  ADR_CTRL      = 6'h00;
  localparam logic [5:0]  ADR_CMD       = 6'h04;
  localparam logic [5:0]  ADR_STAT      = 6'h08;
  localparam logic [5:0]  ADR_EVT       = 6'h0C;
  localparam logic [5:0]  ADR_RXF       = 6'h10;
  localparam logic [5:0]  ADR_TXF       = 6'h14;
  localparam logic [5:0]  ADR_RDL0      = 6'h18;
  localparam logic [5:0]  ADR_RDL1      = 6'h1C;
  localparam logic [5:0]  ADR_RDL2      = 6'h20;
  localparam logic [5:0]  ADR_XDL0      = 6'h24;
  localparam logic [5:0]  ADR_XDL1      = 6'h28;
  localparam logic [5:0]  ADR_XDL2      = 6'h2C;

  // Control register fields
  localparam int          C_HDLC_ACT    = 0;
  localparam int          C_MSG_ACT     = 1;
  localparam int          C_DL_PATH     = 2;
  localparam int          C_SLOT_PATH   = 3;
  localparam int          C_RX_MODE     = 4;
  localparam int          C_FILTER      = 5;
  localparam int          C_DL_REG_TX   = 6;
  localparam int          C_POOL_LO     = 8;
  localparam int          CTRL_W        = 10;
  localparam logic [9:0]  CTRL_RESET    = 10'h001;

  // Command register fields
  localparam int          CMD_RX_RESET  = 0;

  // Event register fields, write one to clear
  localparam int          E_MSG_END     = 0;
  localparam int          E_PAT_INV     = 1;
  localparam int          E_NO_SYNC     = 2;
  localparam int          E_POOL        = 3;
  localparam int          E_RX_MF       = 4;
  localparam int          E_TX_MF       = 5;
  localparam int          E_RX_OVF      = 6;
  localparam int          EVT_W         = 7;

  // Stream constants
  localparam logic [7:0]  SYNC_BYTE     = 8'hFF;
  localparam logic [7:0]  FLAG_BYTE     = 8'h7E;
  localparam logic [7:0]  STATUS_BYTE   = 8'h01;
  localparam logic [3:0]  ONES_RUN      = 4'h8;
  localparam logic [5:0]  SYNC_WINDOW   = 6'h20;
  localparam logic [3:0]  PACKET_BYTES  = 4'hA;
  localparam logic [3:0]  BYTE_LAST     = 4'hF;
  localparam logic [3:0]  BYTE_FIRST    = 4'h8;
  localparam int          FILT_DEPTH    = 10;
  localparam logic [3:0]  FILT_MATCH    = 4'h7;
  localparam logic [5:0]  POOL_32       = 6'h20;
  localparam logic [5:0]  POOL_16       = 6'h10;
  localparam logic [5:0]  POOL_4        = 6'h04;
  localparam logic [5:0]  POOL_2        = 6'h02;
  localparam int          PTR_W         = 5;
  localparam logic [5:0]  FIFO_DEPTH    = 6'h20;
  localparam int          DL_BITS       = 24;

  typedef enum logic [1:0] {
    BDR_ST_HDLC = 2'b01,
    BDR_ST_MSG  = 2'b10
  } bdr_mode_type;

endpackage

/* File: verilog/bdr_mem_if.sv */
// Purpose: Port bundle between the receiver and its byte memories
// Assumes: One write and one registered read port
// Notes:   Read data lag the read address by one clock
`timescale 1ns/10ps
interface bdr_mem_if;
  logic                      we;
  logic [bdr_pkg::PTR_W-1:0] waddr;
  logic [7:0]                wdata;
  logic [bdr_pkg::PTR_W-1:0] raddr;
  logic [7:0]                rdata;
  modport user (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* File: verilog/bdr_mem.sv */
// Purpose: Byte memory for the receive and transmit queues
// Assumes: Single clock, no reset on the storage array
// Notes:   Read data come out of a register
`timescale 1ns/10ps
module bdr_mem (
  input wire logic clk_sys,
  bdr_mem_if.mem   port
);
  logic [7:0] store [0:31];
  logic [7:0] rdata_q;

  always_ff @(posedge clk_sys) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
    rdata_q <= store[port.raddr];
  end

  assign port.rdata = rdata_q;
endmodule // bdr_mem

/* File: verilog/bdr_filter.sv */
// Purpose: Message filter, accepts a pattern seen 7 times in the last 10
// Assumes: load is a one-cycle pulse per sampled byte
// Notes:   accept and lost are one-cycle pulses
`timescale 1ns/10ps
module bdr_filter (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clear,
  input  wire logic       load,
  input  wire logic [7:0] pattern,
  output logic            accept,
  output logic            lost,
  output logic            valid,
  output logic [7:0]      valid_pattern
);
  logic [7:0] hist_q [bdr_pkg::FILT_DEPTH];
  logic [7:0] hist_d [bdr_pkg::FILT_DEPTH];
  logic [bdr_pkg::FILT_DEPTH-1:0] new_eq;
  logic [bdr_pkg::FILT_DEPTH-1:0] old_eq;
  logic [bdr_pkg::FILT_DEPTH-1:0] used_q;
  logic [bdr_pkg::FILT_DEPTH-1:0] used_d;
  logic       accept_q, accept_d, lost_q, lost_d, valid_q, valid_d;
  logic [7:0] vpat_q, vpat_d;
  logic [3:0] new_cnt, old_cnt;

  genvar g;
  generate
    for (g = 0; g < bdr_pkg::FILT_DEPTH; g++) begin : g_entry
      always_comb begin
        hist_d[g] = hist_q[g];
        if (load) begin
          hist_d[g] = (g == 0) ? pattern : hist_q[(g == 0) ? 0 : g-1];
        end
      end
      assign new_eq[g] = used_d[g] && (hist_d[g] == pattern);
      assign old_eq[g] = used_d[g] && (hist_d[g] == vpat_q);
      always_ff @(posedge clk_sys) begin
        hist_q[g] <= hist_d[g];
      end
    end
  endgenerate

  always_comb begin
    new_cnt  = 4'h0;
    old_cnt  = 4'h0;
    used_d   = used_q;
    accept_d = 1'b0;
    lost_d   = 1'b0;
    valid_d  = valid_q;
    vpat_d   = vpat_q;
    if (load) begin
      used_d = {used_q[bdr_pkg::FILT_DEPTH-2:0], 1'b1};
    end
    for (int i = 0; i < bdr_pkg::FILT_DEPTH; i++) begin
      new_cnt = new_cnt + {3'h0, new_eq[i]};
      old_cnt = old_cnt + {3'h0, old_eq[i]};
    end
    if (clear) begin
      used_d  = '0;
      valid_d = 1'b0;
    end else if (load && !valid_q && new_cnt >= bdr_pkg::FILT_MATCH) begin
      valid_d  = 1'b1;
      vpat_d   = pattern;
      accept_d = 1'b1;
    end else if (load && valid_q && old_cnt < bdr_pkg::FILT_MATCH) begin
      valid_d = 1'b0;
      lost_d  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      used_q   <= '0;
      accept_q <= 1'b0;
      lost_q   <= 1'b0;
      valid_q  <= 1'b0;
      vpat_q   <= 8'h00;
    end else begin
      used_q   <= used_d;
      accept_q <= accept_d;
      lost_q   <= lost_d;
      valid_q  <= valid_d;
      vpat_q   <= vpat_d;
    end
  end

  assign accept        = accept_q;
  assign lost          = lost_q;
  assign valid         = valid_q;
  assign valid_pattern = vpat_q;
endmodule // bdr_filter

/* File: tb/bdr_properties.sv */
// Purpose: Port assertions for the message receiver
// Assumes: Bus answers two edges after a request
// Notes:   Sees only the top ports
`timescale 1ns/10ps
module bdr_properties (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        tx_dl_req,
  input wire logic        tx_dl_bit
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
  chk_answer_cause: assert property (!avs_waitrequest |-> $past(avs_read | avs_write, 2)) else $error("stray");
  chk_read_lat: assert property ($rose(avs_read) |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
    else $error("read latency");
  chk_write_lat: assert property ($rose(avs_write) |-> ##2 !avs_waitrequest) else $error("write latency");
  chk_read_zero: assert property (avs_read && !avs_waitrequest && avs_address > 6'h2C |-> avs_readdata == 32'h0)
    else $error("unmapped read");
  chk_read_hold: assert property (!$stable(avs_readdata) |-> !avs_waitrequest && $past(avs_read))
    else $error("data moved");
  chk_reset_vals: assert property ($past(reset) |-> avs_waitrequest && avs_readdata == 32'h0 && tx_dl_bit)
    else $error("reset values");
  chk_tx_hold: assert property (!$past(tx_dl_req) |-> $stable(tx_dl_bit)) else $error("tx bit moved");
endmodule // bdr_properties
bind bdr_receiver bdr_properties u_chk (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .tx_dl_req, .tx_dl_bit);

/* File: tb/bdr_link_model.sv */
// Purpose: Remote terminal on the data link
// Assumes: One receive bit every two clocks, one transmit request every four
// Notes:   Released line shows the inverse bit
`timescale 1ns/10ps
module bdr_link_model (
  input  wire logic clk_sys,
  output logic      rx_dl_bit,
  output logic      rx_dl_valid,
  output logic      rx_mf_begin,
  output logic      tx_dl_req,
  output logic      tx_mf_begin,
  input  wire logic tx_dl_bit
);
  logic [1:0] ph = 2'h0;
  logic [7:0] got;
  int         cap_n = 8;
  initial {rx_dl_bit, rx_dl_valid, rx_mf_begin, tx_dl_req, tx_mf_begin} = 5'h10;
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 16; i++) begin
      {rx_dl_bit, rx_dl_valid} <= {b[i/2] ^ i[0], ~i[0]};
      @(posedge clk_sys);
    end
  endtask
  task automatic pair(input logic [7:0] b);
    send(8'hFF);
    send(b);
  endtask
  task automatic mf(input logic rx_edge, input logic tx_edge);
    rx_mf_begin <= rx_edge;
    tx_mf_begin <= tx_edge;
    @(posedge clk_sys);
    {rx_mf_begin, tx_mf_begin} <= 2'h0;
  endtask
  // First zero opens the capture, idle ones skipped
  always @(posedge clk_sys) begin
    ph <= ph + 2'h1;
    tx_dl_req <= (ph == 2'h3);
    if (ph == 2'h2 && cap_n < 8 && (cap_n != 0 || !tx_dl_bit)) begin
      got <= {tx_dl_bit, got[7:1]};
      cap_n <= cap_n + 1;
    end
  end
endmodule // bdr_link_model

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the message receiver
// Assumes: Link model drives the line side
// Notes:   Expected values follow the register map
`timescale 1ns/10ps
module testbench;
  logic        clk_sys, reset, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        rx_dl_bit, rx_dl_valid, rx_mf_begin, tx_dl_req, tx_mf_begin, tx_dl_bit;
  int          fail_count = 0, cmp_count = 0, cycles = 0;
  bdr_receiver u_dut (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .rx_dl_bit, .rx_dl_valid, .rx_mf_begin, .tx_dl_req, .tx_mf_begin, .tx_dl_bit);
  bdr_link_model u_link (.clk_sys, .rx_dl_bit, .rx_dl_valid, .rx_mf_begin, .tx_dl_req, .tx_mf_begin, .tx_dl_bit);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys) if (++cycles == 5000) begin
    fail_count++;
    conclude();
  end
  task automatic chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, ~w};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  initial begin
    reset = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(6'h00, 32'h1);
    rd(6'h08, 32'h4);
    rd(6'h3C, 32'h0);
    bus(1'b1, 6'h00, 32'h6);
    u_link.send(8'hFF);
    u_link.send(8'h80);
    u_link.send(8'h00);
    u_link.send(8'hC3);
    repeat (10) u_link.pair(8'h42);
    rd(6'h08, 32'hB01);
    repeat (10) rd(6'h10, 32'h42);
    rd(6'h10, 32'h1);
    rd(6'h0C, 32'h1);
    bus(1'b1, 6'h0C, 32'h7F);
    repeat (5) u_link.send(8'h42);
    u_link.send(8'h7E);
    rd(6'h08, 32'h200);
    repeat (2) rd(6'h10, 32'h42);
    rd(6'h0C, 32'h4);
    $display("test packet done");
    bus(1'b1, 6'h0C, 32'h7F);
    u_link.pair(8'hFF);
    rd(6'h08, 32'h5);
    bus(1'b1, 6'h04, 32'h1);
    rd(6'h08, 32'h4);
    u_link.send(8'hFF);
    bus(1'b1, 6'h00, 32'h4);
    rd(6'h08, 32'h100);
    rd(6'h10, 32'h1);
    rd(6'h0C, 32'h1);
    bus(1'b1, 6'h0C, 32'h7F);
    $display("test disable done");
    u_link.cap_n = 0;
    bus(1'b1, 6'h14, 32'h5A);
    wait (u_link.cap_n == 8);
    @(posedge clk_sys);
    chk({24'h0, u_link.got}, 32'h5A);
    bus(1'b1, 6'h00, 32'h5);
    u_link.pair(8'hFF);
    rd(6'h08, 32'h200);
    repeat (2) rd(6'h10, 32'hFF);
    bus(1'b1, 6'h00, 32'h40);
    for (int i = 1; i < 4; i++) u_link.send(8'h11 * i[7:0]);
    u_link.mf(1'b1, 1'b1);
    @(posedge clk_sys);
    for (int i = 0; i < 3; i++) rd(6'h18 + 6'(4 * i), 32'h11 * (i + 1));
    rd(6'h0C, 32'h30);
    $display("test link done");
    conclude();
  end
endmodule // testbench
